// ==== hw/tcc_map.svh ====
/*
  Register offsets, field positions, reset values and counts for the
  timer clock control block.
  Assumes it is included by bare name, once per compilation unit.
*/
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// Byte offsets on the AHB-Lite bus, one aligned word each.
`define TCC_OFS_CTRL       8'h00
`define TCC_OFS_COUNT      8'h04
`define TCC_OFS_STATUS     8'h08
`define TCC_ADDR_W         8

// Control register fields.
`define TCC_CTRL_SRC_HI    7
`define TCC_CTRL_SRC_LO    6
`define TCC_CTRL_DIV_HI    5
`define TCC_CTRL_DIV_LO    4
`define TCC_CTRL_XTAL      3
`define TCC_CTRL_BYPASS    2
`define TCC_CTRL_ON        0
`define TCC_CTRL_WMASK     8'hFD
`define TCC_CTRL_RESET     8'h00

// Status register fields; bits 0 and 1 are write-one-to-clear.
`define TCC_ST_OVF         0
`define TCC_ST_GATE        1
`define TCC_ST_LEVEL       2

// Count and divider constants.
`define TCC_COUNT_RESET    16'h0000
`define TCC_COUNT_MAX      16'hFFFF
`define TCC_ICLK_LAST      2'h3
`define TCC_PRE_LAST_1     3'h0
`define TCC_PRE_LAST_2     3'h1
`define TCC_PRE_LAST_4     3'h3
`define TCC_PRE_LAST_8     3'h7

`endif

// ==== hw/tcc_pkg.sv ====
/*
  Types for the timer clock control block.
  Assumes tcc_map.svh supplies the numeric constants.
*/
package tcc_pkg;
  // Count clock sources in field order.
  typedef enum logic [1:0] {
    TCC_SRC_INSTR,
    TCC_SRC_SYS,
    TCC_SRC_EXT,
    TCC_SRC_CAP
  } tcc_src_e;
endpackage

// ==== hw/tcc_timer1_clock_control.sv ====
/*
  Timer clock control: source select, prescaler, 16-bit counter with
  overflow and gate event flags, behind an AHB-Lite slave.
  Assumes every input but the pin and crystal is synchronous to mclk and a single bus master
  issuing whole-word single transfers.
*/
// Contract
// R1: Field bits 7-6 select instruction clock, system clock, pin/crystal or cap oscillator.
// R2: Field bits 5-4 divide selected edges by 1, 2, 4 or 8.
// R3: Bit 3 enables crystal oscillator and picks crystal over pin for source 10.
// R4: Bit 2 set passes external clock raw; clear synchronises it; internal ignore.
// R5: Bit 1 reads zero; bit 0 lets the counter count.
// R6: Counter wraps FFFF to 0000 and sets the overflow flag.
// R7: Falling gate level sets gate event flag, cleared by software.
`timescale 1ns/1ps
`include "tcc_map.svh"

module tcc_timer1_clock_control
  import tcc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        external_count_pin,
  input  wire logic        crystal_clock_in,
  input  wire logic        cap_sense_oscillator,
  input  wire logic        gate_level,
  output logic             crystal_oscillator_enable,
  output logic [15:0]      count_value,
  output logic             overflow_flag,
  output logic             gate_event_flag
);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave state.
  logic [`TCC_ADDR_W-1:0] addr_r, addr_nxt;
  logic                   wr_r, wr_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic                   ctl_wr, cnt_wr, st_wr;

  // Block state.
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        ovf_r, ovf_nxt;
  logic        gev_r, gev_nxt;
  logic        glev_r, glev_nxt;
  logic [1:0]  iclk_r, iclk_nxt;
  logic [2:0]  pre_r, pre_nxt;
  logic        sel_prev_r, sel_prev_nxt;

  // Synchroniser chains for pin and crystal, plus the raw input pair.
  logic [1:0]  ext_in;
  logic [1:0]  sync1_r;
  logic [1:0]  sync2_r;

  // Decoded controls.
  tcc_src_e    src;
  logic [1:0]  div_sel;
  logic        xtal_en, bypass, on;
  logic        ext_lvl, sel_lvl, raw_edge, src_tick, pre_tick;

  assign src     = tcc_src_e'(ctrl_r[`TCC_CTRL_SRC_HI:`TCC_CTRL_SRC_LO]);
  assign div_sel = ctrl_r[`TCC_CTRL_DIV_HI:`TCC_CTRL_DIV_LO];
  assign xtal_en = ctrl_r[`TCC_CTRL_XTAL];
  assign bypass  = ctrl_r[`TCC_CTRL_BYPASS];
  assign on      = ctrl_r[`TCC_CTRL_ON];
  assign ext_in  = {crystal_clock_in, external_count_pin};

  // Last prescaler count for a divider code; used only by pre_tick.
  function automatic logic [2:0] pre_last(input logic [1:0] sel);
    case (sel)
      2'h0:    pre_last = `TCC_PRE_LAST_1;
      2'h1:    pre_last = `TCC_PRE_LAST_2;
      2'h2:    pre_last = `TCC_PRE_LAST_4;
      default: pre_last = `TCC_PRE_LAST_8;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; the first stage feeds only the second.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= ext_in[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Source edge selection. The bypass path saves two cycles of latency
  // but counts on the input already meeting mclk timing.
  always_comb begin
    // R3: crystal or pin
    if (xtal_en) begin
      ext_lvl = bypass ? crystal_clock_in : sync2_r[1];
    end else begin
      // R4: sync or bypass
      ext_lvl = bypass ? external_count_pin : sync2_r[0];
    end
    sel_lvl = (src == TCC_SRC_CAP) ? cap_sense_oscillator : ext_lvl;
    raw_edge = sel_lvl && !sel_prev_r;
    // R1: source select
    case (src)
      TCC_SRC_INSTR: src_tick = (iclk_r == `TCC_ICLK_LAST);
      TCC_SRC_SYS:   src_tick = 1'b1;
      TCC_SRC_EXT:   src_tick = raw_edge;
      TCC_SRC_CAP:   src_tick = raw_edge;
      default:       src_tick = 1'b0;
    endcase
    // A count left over from a larger ratio closes the period at once.
    // R2: prescale divide
    pre_tick = src_tick && (pre_r >= pre_last(div_sel));
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: address phase captured, write performed in data phase.
  always_comb begin
    addr_nxt  = addr_r;
    wr_nxt    = 1'b0;
    rdata_nxt = rdata_r;
    if (hsel && htrans[1] && hready) begin
      addr_nxt = haddr[`TCC_ADDR_W-1:0];
      wr_nxt   = hwrite;
      case (haddr[`TCC_ADDR_W-1:0])
        // R5: bit 1 reads zero
        `TCC_OFS_CTRL:   rdata_nxt = {24'h00_0000, ctrl_r};
        `TCC_OFS_COUNT:  rdata_nxt = {16'h0000, cnt_r};
        `TCC_OFS_STATUS: rdata_nxt = {29'h0000_0000, glev_r, gev_r, ovf_r};
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  assign ctl_wr    = wr_r && (addr_r == `TCC_OFS_CTRL);
  assign cnt_wr    = wr_r && (addr_r == `TCC_OFS_COUNT);
  assign st_wr     = wr_r && (addr_r == `TCC_OFS_STATUS);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_r  <= `TCC_OFS_CTRL;
      wr_r    <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      addr_r  <= addr_nxt;
      wr_r    <= wr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, dividers and flags. Hardware sets win over software clears.
  always_comb begin
    ctrl_nxt     = ctl_wr ? (hwdata[7:0] & `TCC_CTRL_WMASK) : ctrl_r;
    iclk_nxt     = iclk_r + 2'h1;
    sel_prev_nxt = sel_lvl;
    glev_nxt     = gate_level;
    pre_nxt      = pre_r;
    cnt_nxt      = cnt_r;
    ovf_nxt      = ovf_r;
    gev_nxt      = gev_r;
    if (st_wr && hwdata[`TCC_ST_OVF]) begin
      ovf_nxt = 1'b0;
    end
    if (st_wr && hwdata[`TCC_ST_GATE]) begin
      gev_nxt = 1'b0;
    end
    // R5: on bit gates counting
    if (on && src_tick) begin
      pre_nxt = pre_tick ? 3'h0 : pre_r + 3'h1;
    end
    if (cnt_wr) begin
      cnt_nxt = hwdata[15:0];
    end else if (on && pre_tick) begin
      cnt_nxt = cnt_r + 16'h0001;
      // R6: wrap sets overflow
      if (cnt_r == `TCC_COUNT_MAX) begin
        ovf_nxt = 1'b1;
      end
    end
    // R7: falling gate edge
    if (glev_r && !gate_level) begin
      gev_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r     <= `TCC_CTRL_RESET;
      cnt_r      <= `TCC_COUNT_RESET;
      ovf_r      <= 1'b0;
      gev_r      <= 1'b0;
      glev_r     <= 1'b0;
      iclk_r     <= 2'h0;
      pre_r      <= 3'h0;
      sel_prev_r <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      cnt_r      <= cnt_nxt;
      ovf_r      <= ovf_nxt;
      gev_r      <= gev_nxt;
      glev_r     <= glev_nxt;
      iclk_r     <= iclk_nxt;
      pre_r      <= pre_nxt;
      sel_prev_r <= sel_prev_nxt;
    end
  end

  // Outputs come straight from flip-flops.
  assign crystal_oscillator_enable = ctrl_r[`TCC_CTRL_XTAL];
  assign count_value               = cnt_r;
  assign overflow_flag             = ovf_r;
  assign gate_event_flag           = gev_r;
  assign hrdata                    = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  a_sys_clock_count: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    (on && src == TCC_SRC_SYS && div_sel == 2'h0 && !cnt_wr && !ctl_wr)
      |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("system clock source did not count every cycle");

  a_div8_spacing: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    (pre_tick && on && src == TCC_SRC_SYS && div_sel == 2'h3 && !ctl_wr)
      |=> (!pre_tick)[*7] ##1 (pre_tick || !on || $past(ctl_wr)))
    else $error("divide by eight spacing wrong");

  a_xtal_edge_pick: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    (src == TCC_SRC_EXT && xtal_en && bypass && crystal_clock_in && !sel_prev_r)
      |-> src_tick)
    else $error("crystal edge not taken as count source");

  a_sync_latency: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    (src == TCC_SRC_EXT && !xtal_en && !bypass && !ctl_wr && $rose(external_count_pin))
      ##1 !ctl_wr |-> ##1 raw_edge)
    else $error("synchronised edge not seen two cycles later");

  a_off_holds: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    (!on && !cnt_wr) |=> cnt_r == $past(cnt_r))
    else $error("counter moved while switched off");

  a_wrap_flag: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    (on && pre_tick && !cnt_wr && cnt_r == `TCC_COUNT_MAX)
      |=> cnt_r == `TCC_COUNT_RESET && ovf_r)
    else $error("wrap did not clear count and set overflow");

  a_gate_fall: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    $fell(gate_level) |=> ##1 gev_r)
    else $error("gate falling edge did not set event flag");

endmodule

// ==== sim/tcc_src_model.sv ====
/*
  Far-side model: external count pin, crystal and capacitive oscillator.
  Assumes the sources run free and each has its own period in mclk cycles.
*/
`timescale 1ns/1ps

module tcc_src_model #(
  parameter int PIN_HALF  = 3,
  parameter int XTAL_HALF = 5,
  parameter int CAP_HALF  = 7
) (
  input  wire logic mclk,
  output logic      external_count_pin,
  output logic      crystal_clock_in,
  output logic      cap_sense_oscillator
);
  int cnt_r = 0;

  // Free-running cycle count; real oscillators do not stop between uses.
  always @(posedge mclk) begin
    cnt_r <= cnt_r + 1;
  end

  assign external_count_pin = cnt_r / PIN_HALF % 2 == 1;
  assign cap_sense_oscillator = cnt_r / CAP_HALF % 2 == 1;
  assign crystal_clock_in = cnt_r / XTAL_HALF % 2 == 1;
endmodule

// ==== sim/timer1_clock_control_test.sv ====
/*
  Self-checking bench for the timer clock control block.
  Assumes a zero-wait AHB-Lite slave and the source model beside it.
*/
`timescale 1ns/1ps
`include "tcc_map.svh"

module timer1_clock_control_test
  import tcc_pkg::*;
;
  logic        mclk       = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0000_0000;
  logic [1:0]  htrans     = 2'b00;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0000_0000;
  logic        gate_level = 1'b1;
  logic        dph_r      = 1'b0;
  logic        hreadyout, hresp, pin, xtal, cap, xen, ovf, gev;
  logic [31:0] hrdata;
  logic [15:0] cnt;
  logic [31:0] exp_q[$];
  int          tol_q[$];
  int          err_total  = 0;
  int          checked    = 0;

  always #2 mclk = ~mclk;

  tcc_timer1_clock_control u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_count_pin(pin), .crystal_clock_in(xtal), .cap_sense_oscillator(cap),
    .gate_level(gate_level), .crystal_oscillator_enable(xen), .count_value(cnt),
    .overflow_flag(ovf), .gate_event_flag(gev)
  );

  tcc_src_model u_src (
    .mclk(mclk), .external_count_pin(pin), .crystal_clock_in(xtal), .cap_sense_oscillator(cap)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A tolerance lets rate checks absorb bus latency and prescaler phase.
  task automatic cmp_val(input string nm, input logic [31:0] e, input int tol, input logic [31:0] s);
    checked++;
    if (^s === 1'bx || (tol == 0 ? s !== e : (s > e + tol || s + tol < e))) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, s);
    end
  endtask

  // Waits for hready at a rising edge, bounded so a hang ends the run.
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        test_done();
      end
      @(posedge mclk);
    end
  endtask

  // One single word transfer; reads note their expectation first.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input int tol = 0);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    if (!w) begin
      exp_q.push_back(d);
      tol_q.push_back(tol);
    end
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    if (w) hwdata <= d;
    wait_rdy();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read data and response are judged at the edge ending each data phase.
  always @(posedge mclk) begin
    if (dph_r && hreadyout === 1'b1 && exp_q.size() > 0) begin
      cmp_val("hrdata", exp_q.pop_front(), tol_q.pop_front(), hrdata);
      cmp_val("hresp", 32'h0000_0000, 0, {31'h0, hresp});
    end
    dph_r <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
  end

  initial begin
    logic [7:0]  cfg;
    logic [15:0] rv;
    int          p;
    void'($urandom(3732));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(`TCC_OFS_CTRL, 0, 0);
    bus(`TCC_OFS_COUNT, 0, 0);
    bus(8'h0C, 0, 0);
    bus(`TCC_OFS_CTRL, 1, 8'hFE);
    bus(`TCC_OFS_CTRL, 0, 8'hFC);
    cmp_val("xtal_en", 1, 0, {31'h0, xen});
    rv = 16'($urandom);
    bus(`TCC_OFS_COUNT, 1, rv);
    bus(`TCC_OFS_COUNT, 0, rv);
    // Every source and divider, with random crystal and bypass bits except for source 10.
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 4; v++) begin
        // The pin source walks every crystal and bypass pair; the others take random bits.
        cfg = {s[1:0], v[1:0], (s == 2) ? v[1:0] : 2'($urandom), 2'b01};
        p = s == 0 ? 4 : s == 1 ? 1 : s == 3 ? 14 : cfg[3] ? 10 : 6;
        bus(`TCC_OFS_COUNT, 1, 0);
        bus(`TCC_OFS_CTRL, 1, cfg);
        repeat (800) @(posedge mclk);
        bus(`TCC_OFS_CTRL, 1, cfg & 8'hFE);
        bus(`TCC_OFS_COUNT, 0, 802 / (p << v), 3);
        cmp_val("count_value", 802 / (p << v), 3, {16'h0000, cnt});
        bus(`TCC_OFS_CTRL, 0, cfg & 8'hFC);
      end
    end
    bus(`TCC_OFS_COUNT, 1, 16'hFFF8);
    bus(`TCC_OFS_CTRL, 1, 8'h41);
    repeat (10) @(posedge mclk);
    bus(`TCC_OFS_CTRL, 1, 8'h00);
    bus(`TCC_OFS_COUNT, 0, 4, 2);
    cmp_val("count_value", 4, 2, {16'h0000, cnt});
    bus(`TCC_OFS_STATUS, 0, 5);
    cmp_val("overflow", 1, 0, {31'h0, ovf});
    bus(`TCC_OFS_STATUS, 1, 1);
    bus(`TCC_OFS_STATUS, 0, 4);
    gate_level <= 1'b0;
    repeat (3) @(posedge mclk);
    bus(`TCC_OFS_STATUS, 0, 2);
    cmp_val("gate_event", 1, 0, {31'h0, gev});
    bus(`TCC_OFS_STATUS, 1, 2);
    bus(`TCC_OFS_STATUS, 0, 0);
    repeat (2) @(posedge mclk);
    test_done();
  end
endmodule
